// [logic/acs_input_config.sv]
// Serial configuration receiver with input configuration and custom scan registers
// Function
// - Select code 10001 loads the pseudo-differential register from the word
// - Select code 10010 loads the bipolar selection register from the word
// - Select code 10100 loads the scan mask for channels 15 to 8
// - Select code 10101 loads the scan mask for channels 7 to 0
// - Bits 10:3 pick pseudo-differential per pair, pair 0/1 first; reset 0
// - Bit 2 refers channels 0 to 14 to channel 15; reset 0
// - Bits 10:3 pick bipolar differential per pair; reset 0
// - Upper mask bits 10:3 include channels 15 down to 8; reset 0
// - Lower mask bits 10:3 include channels 7 down to 0; reset 0
// - Bipolar only gives differential pair, two's complement output
// - Pseudo and bipolar both set: pseudo wins, straight binary
// - Common reference mode forces channel-15 reference, straight binary
// - Combined scan mask applies only in the two custom scan modes
`timescale 1ns/1ps
`default_nettype none

module acs_input_config (
  input wire logic clk,
  input wire logic rst,
  input wire acs_pkg::acs_pins_type serial_pins,
  input wire logic mask_scan_external_clock,
  input wire logic mask_scan_internal_clock,
  input wire logic [3:0] conv_channel,
  output var acs_pkg::acs_cfg_type cfg,
  output logic [15:0] channel_scan_mask,
  output var acs_pkg::acs_kind_type conv_kind,
  output logic twos_complement,
  output logic [31:0] channel_kinds,
  output logic cfg_load_strobe
);

  // Kind of one channel from its pair bits and the common mode
  function automatic acs_pkg::acs_kind_type kind_of(
    input logic pd,
    input logic bp,
    input logic com
  );
    acs_pkg::acs_kind_type k;
    if (com)
      k = acs_pkg::KIND_COMMON_REF;
    else if (pd)
      k = acs_pkg::KIND_PAIR_PSEUDO;
    else if (bp)
      k = acs_pkg::KIND_PAIR_BIPOLAR;
    else
      k = acs_pkg::KIND_SINGLE;
    return k;
  endfunction

  acs_pkg::acs_pins_type pins_s;
  logic sclk_prev;
  logic next_sclk_prev;
  logic sclk_rise;
  logic cs_active;
  acs_pkg::acs_frame_type state;
  acs_pkg::acs_frame_type next_state;
  logic [4:0] bit_count;
  logic [4:0] next_bit_count;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic [15:0] word_q;
  logic [15:0] next_word_q;
  logic word_valid;
  logic next_word_valid;
  logic shift_now;
  acs_pkg::acs_cfg_type next_cfg;
  logic next_cfg_load_strobe;
  logic [15:0] next_channel_scan_mask;
  logic custom_mode;
  logic [2:0] cur_pair;
  logic [2:0] cur_index;
  logic cur_pd;
  logic cur_bp;
  logic cur_com;
  acs_pkg::acs_kind_type next_conv_kind;
  logic next_twos_complement;
  logic [31:0] next_channel_kinds;

  // Pins cross into clk through two flops before any logic reads them
  acs_sync #(
    .WIDTH(3),
    .STAGES(acs_pkg::SYNC_STAGES),
    .RESET_VALUE(acs_pkg::PINS_IDLE)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in(serial_pins),
    .sync_out(pins_s)
  );

  // Edge detect on the already synchronised serial clock
  assign sclk_rise = pins_s.sclk & ~sclk_prev;
  assign cs_active = ~pins_s.cs_n;
  assign shift_now = cs_active && sclk_rise && (state != acs_pkg::FR_HOLD);

  // Frame receiver: 16 bits on rising serial edges, extra bits ignored
  always_comb
  begin
    next_sclk_prev = pins_s.sclk;
    next_state = state;
    next_bit_count = bit_count;
    next_shreg = shreg;
    next_word_q = word_q;
    next_word_valid = 1'b0;
    if (shift_now)
    begin
      next_shreg = {shreg[14:0], pins_s.din};
      next_bit_count = bit_count + 5'h01;
    end
    case (state)
      acs_pkg::FR_IDLE:
      begin
        next_bit_count = shift_now ? 5'h01 : 5'h00;
        if (cs_active)
          next_state = acs_pkg::FR_SHIFT;
      end
      acs_pkg::FR_SHIFT:
      begin
        // A frame cut short by chip select is dropped whole
        if (!cs_active)
          next_state = acs_pkg::FR_IDLE;
        else if (shift_now && bit_count == acs_pkg::LAST_BIT_INDEX)
        begin
          next_word_q = {shreg[14:0], pins_s.din};
          next_word_valid = 1'b1;
          next_state = acs_pkg::FR_HOLD;
        end
      end
      acs_pkg::FR_HOLD:
      begin
        if (!cs_active)
          next_state = acs_pkg::FR_IDLE;
      end
      default:
      begin
        next_state = acs_pkg::FR_IDLE;
      end
    endcase
  end

  // Frame receiver registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclk_prev <= 1'b0;
      state <= acs_pkg::FR_IDLE;
      bit_count <= 5'h00;
      shreg <= 16'h0000;
      word_q <= 16'h0000;
      word_valid <= 1'b0;
    end
    else
    begin
      sclk_prev <= next_sclk_prev;
      state <= next_state;
      bit_count <= next_bit_count;
      shreg <= next_shreg;
      word_q <= next_word_q;
      word_valid <= next_word_valid;
    end
  end

  // Register loads by select code; mode words (first bit 0) never match
  always_comb
  begin
    next_cfg = cfg;
    next_cfg_load_strobe = 1'b0;
    if (word_valid && word_q[acs_pkg::SEL_HI])
    begin
      case (word_q[acs_pkg::SEL_HI:acs_pkg::SEL_LO])
        acs_pkg::PD_SEL_CODE:
        begin
          next_cfg.pair_pseudo_diff_bit = word_q[acs_pkg::FIELD_HI:acs_pkg::FIELD_LO];
          next_cfg.common_reference_mode = word_q[acs_pkg::COMMON_BIT];
          next_cfg_load_strobe = 1'b1;
        end
        acs_pkg::BIP_SEL_CODE:
        begin
          next_cfg.pair_bipolar_bit = word_q[acs_pkg::FIELD_HI:acs_pkg::FIELD_LO];
          next_cfg_load_strobe = 1'b1;
        end
        acs_pkg::UPPER_SEL_CODE:
        begin
          next_cfg.scan_mask_upper = word_q[acs_pkg::FIELD_HI:acs_pkg::FIELD_LO];
          next_cfg_load_strobe = 1'b1;
        end
        acs_pkg::LOWER_SEL_CODE:
        begin
          next_cfg.scan_mask_lower = word_q[acs_pkg::FIELD_HI:acs_pkg::FIELD_LO];
          next_cfg_load_strobe = 1'b1;
        end
        default:
        begin
          next_cfg_load_strobe = 1'b0;
        end
      endcase
    end
  end

  // Configuration registers, all cleared at reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg.pair_pseudo_diff_bit <= acs_pkg::FIELD_RESET;
      cfg.common_reference_mode <= acs_pkg::COMMON_RESET;
      cfg.pair_bipolar_bit <= acs_pkg::FIELD_RESET;
      cfg.scan_mask_upper <= acs_pkg::FIELD_RESET;
      cfg.scan_mask_lower <= acs_pkg::FIELD_RESET;
      cfg_load_strobe <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      cfg_load_strobe <= next_cfg_load_strobe;
    end
  end

  // Mask reaches the sequencer only in custom scan modes
  assign custom_mode = mask_scan_external_clock | mask_scan_internal_clock;

  always_comb
  begin
    next_channel_scan_mask = acs_pkg::MASK_RESET;
    if (custom_mode)
      next_channel_scan_mask = {cfg.scan_mask_upper, cfg.scan_mask_lower};
  end

  // Scan mask output register
  always_ff @(posedge clk)
  begin
    if (rst)
      channel_scan_mask <= acs_pkg::MASK_RESET;
    else
      channel_scan_mask <= next_channel_scan_mask;
  end

  // Pair 0/1 lives in field bit 7 (word bit 10), so the index runs downward
  assign cur_pair = conv_channel[3:1];
  assign cur_index = acs_pkg::TOP_PAIR - cur_pair;
  assign cur_pd = cfg.pair_pseudo_diff_bit[cur_index];
  assign cur_bp = cfg.pair_bipolar_bit[cur_index];
  assign cur_com = cfg.common_reference_mode;

  // Coding of the channel now converting and of every channel
  always_comb
  begin
    next_conv_kind = kind_of(cur_pd, cur_bp, cur_com);
    next_twos_complement = (next_conv_kind == acs_pkg::KIND_PAIR_BIPOLAR);
    for (int c = 0; c < acs_pkg::CHANNELS; c++)
    begin
      next_channel_kinds[2*c +: 2] = kind_of(cfg.pair_pseudo_diff_bit[7 - c/2],
        cfg.pair_bipolar_bit[7 - c/2], cur_com);
    end
  end

  // Coding registers; a change in setup shows one cycle later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conv_kind <= acs_pkg::KIND_SINGLE;
      twos_complement <= 1'b0;
      channel_kinds <= 32'h00000000;
    end
    else
    begin
      conv_kind <= next_conv_kind;
      twos_complement <= next_twos_complement;
      channel_kinds <= next_channel_kinds;
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_word(logic [4:0] code);
    word_valid && word_q[15:11] == code;
  endsequence

  sequence s_loaded;
    ##1 cfg_load_strobe;
  endsequence

  chk_pd_load: assert property (s_word(acs_pkg::PD_SEL_CODE) |-> s_loaded ##0
    (cfg.pair_pseudo_diff_bit == $past(word_q[10:3]) && cfg.common_reference_mode == $past(word_q[2])))
    else $error("pseudo-differential register not loaded");

  chk_bip_load: assert property (s_word(acs_pkg::BIP_SEL_CODE) |-> s_loaded ##0
    (cfg.pair_bipolar_bit == $past(word_q[10:3]) && $stable(cfg.pair_pseudo_diff_bit)))
    else $error("bipolar register not loaded");

  chk_upper_load: assert property (s_word(acs_pkg::UPPER_SEL_CODE) |=>
    cfg.scan_mask_upper == $past(word_q[10:3]) && $stable(cfg.scan_mask_lower))
    else $error("upper scan mask not loaded");

  chk_lower_load: assert property (s_word(acs_pkg::LOWER_SEL_CODE) |=>
    cfg.scan_mask_lower == $past(word_q[10:3]) && $stable(cfg.scan_mask_upper))
    else $error("lower scan mask not loaded");

  chk_mode_word_ignored: assert property (word_valid && !word_q[15] |=>
    $stable(cfg) && !cfg_load_strobe)
    else $error("mode control word changed configuration");

  chk_bipolar_coding: assert property (cur_bp && !cur_pd && !cur_com |=>
    conv_kind == acs_pkg::KIND_PAIR_BIPOLAR && twos_complement)
    else $error("bipolar pair not coded two's complement");

  chk_pseudo_wins: assert property (cur_bp && cur_pd && !cur_com |=>
    conv_kind == acs_pkg::KIND_PAIR_PSEUDO && !twos_complement)
    else $error("pseudo-differential did not take precedence");

  chk_common_ref: assert property (cur_com |=>
    conv_kind == acs_pkg::KIND_COMMON_REF && !twos_complement)
    else $error("common reference mode not applied");

  chk_single_ended: assert property (!cur_bp && !cur_pd && !cur_com |=>
    conv_kind == acs_pkg::KIND_SINGLE && !twos_complement)
    else $error("single-ended coding wrong");

  chk_mask_gate: assert property (custom_mode |=> channel_scan_mask ==
    $past({cfg.scan_mask_upper, cfg.scan_mask_lower}))
    else $error("scan mask not passed in custom mode");

  chk_mask_off: assert property (!custom_mode |=> channel_scan_mask == 16'h0000)
    else $error("scan mask leaked outside custom mode");

  chk_reset_clear: assert property (disable iff (1'b0) $past(rst) && rst |->
    cfg.pair_pseudo_diff_bit == 8'h00 && cfg.pair_bipolar_bit == 8'h00 && !cfg.common_reference_mode)
    else $error("configuration not cleared at reset");

endmodule

`default_nettype wire

// [logic/acs_pkg.sv]
// Constants, types and carriers shared by the input configuration block
package acs_pkg;

  // Serial word layout
  localparam int WORD_BITS = 16;
  localparam int SEL_HI = 15;
  localparam int SEL_LO = 11;
  localparam int FIELD_HI = 10;
  localparam int FIELD_LO = 3;
  localparam int COMMON_BIT = 2;
  localparam int PAIRS = 8;
  localparam int CHANNELS = 16;
  localparam int SYNC_STAGES = 2;
  // Pins at rest: chip select high, clock and data low
  localparam logic [2:0] PINS_IDLE = 3'h4;

  // Register select codes in bits 15:11
  localparam logic [4:0] PD_SEL_CODE = 5'h11;
  localparam logic [4:0] BIP_SEL_CODE = 5'h12;
  localparam logic [4:0] UPPER_SEL_CODE = 5'h14;
  localparam logic [4:0] LOWER_SEL_CODE = 5'h15;

  // Reset values and counts
  localparam logic [7:0] FIELD_RESET = 8'h00;
  localparam logic COMMON_RESET = 1'b0;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [4:0] LAST_BIT_INDEX = 5'h0F;
  localparam logic [2:0] TOP_PAIR = 3'h7;

  // Conversion kind of one channel
  typedef enum logic [1:0] {
    KIND_SINGLE = 2'b00,
    KIND_PAIR_BIPOLAR = 2'b01,
    KIND_PAIR_PSEUDO = 2'b10,
    KIND_COMMON_REF = 2'b11
  } acs_kind_type;

  // Serial frame receiver states
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SHIFT = 2'b01,
    FR_HOLD = 2'b10
  } acs_frame_type;

  // Three-wire serial pins as they arrive
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } acs_pins_type;

  // Configuration register contents, field bits 10:3 and bit 2
  typedef struct packed {
    logic [7:0] pair_pseudo_diff_bit;
    logic common_reference_mode;
    logic [7:0] pair_bipolar_bit;
    logic [7:0] scan_mask_upper;
    logic [7:0] scan_mask_lower;
  } acs_cfg_type;

endpackage

// [logic/acs_sync.sv]
// Multi-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module acs_sync #(
  parameter int WIDTH = 3,
  parameter int STAGES = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage [STAGES];
  logic [WIDTH-1:0] next_stage [STAGES];

  // First stage feeds only the next stage, never other logic
  always_comb
  begin
    next_stage[0] = async_in;
    for (int i = 1; i < STAGES; i++)
    begin
      next_stage[i] = stage[i-1];
    end
  end

  // Stage registers; reset parks pins at their idle level so no false edge follows
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < STAGES; i++)
    begin
      if (rst)
        stage[i] <= RESET_VALUE;
      else
        stage[i] <= next_stage[i];
    end
  end

  assign sync_out = stage[STAGES-1];

endmodule

`default_nettype wire

// [test/acs_host_model.sv]
// Serial host model that frames one configuration word per chip-select cycle
`timescale 1ns/1ps
`default_nettype none

module acs_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] word,
  input wire logic [4:0] nbits,
  input wire logic [3:0] half,
  output var acs_pkg::acs_pins_type pins,
  output logic busy
);
  logic [15:0] w;
  int n;
  int h;
  int i;

  // Pins change on falling clock edges only, with a start taken at a rising edge
  initial
  begin
    pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (start === 1'b1 && rst === 1'b0)
      begin
        busy = 1'b1;
        w = word;
        n = int'(nbits);
        h = int'(half);
        @(negedge clk);
        pins.cs_n = 1'b0;
        repeat (h) @(negedge clk);
        for (i = 0; i < n; i++)
        begin
          // Bits past the sixteenth alternate; the receiver must drop them
          pins.din = (i < 16) ? w[15 - i] : i[0];
          repeat (h) @(negedge clk);
          pins.sclk = 1'b1;
          repeat (h) @(negedge clk);
          pins.sclk = 1'b0;
        end
        repeat (h) @(negedge clk);
        pins.cs_n = 1'b1;
        // Released data line shows the inverse, never the last bit
        pins.din = ~pins.din;
        repeat (h) @(negedge clk);
        busy = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// [test/acs_input_config_tb.sv]
// Self-checking bench for the input configuration and scan mask registers
`timescale 1ns/1ps
`default_nettype none

module acs_input_config_tb;
  logic clk;
  logic rst;
  logic start;
  logic [15:0] word;
  logic [4:0] nbits;
  logic [3:0] half;
  logic busy;
  acs_pkg::acs_pins_type pins;
  logic ext_mode;
  logic int_mode;
  logic [3:0] conv_channel;
  acs_pkg::acs_cfg_type cfg;
  logic [15:0] channel_scan_mask;
  acs_pkg::acs_kind_type conv_kind;
  logic twos_complement;
  logic [31:0] channel_kinds;
  logic cfg_load_strobe;
  int bad_count;
  int checked;
  int strobes = 0;
  logic [7:0] e_pd;
  logic [7:0] e_bp;
  logic [7:0] e_up;
  logic [7:0] e_lo;
  logic e_com;

  acs_input_config dut (
    .clk(clk),
    .rst(rst),
    .serial_pins(pins),
    .mask_scan_external_clock(ext_mode),
    .mask_scan_internal_clock(int_mode),
    .conv_channel(conv_channel),
    .cfg(cfg),
    .channel_scan_mask(channel_scan_mask),
    .conv_kind(conv_kind),
    .twos_complement(twos_complement),
    .channel_kinds(channel_kinds),
    .cfg_load_strobe(cfg_load_strobe)
  );

  acs_host_model host (
    .clk(clk),
    .rst(rst),
    .start(start),
    .word(word),
    .nbits(nbits),
    .half(half),
    .pins(pins),
    .busy(busy)
  );

  // Clock at 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Load pulses counted on falling edges, where the strobe has settled
  always @(negedge clk)
  begin
    if (cfg_load_strobe === 1'b1)
      strobes <= strobes + 1;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] wd(input logic [4:0] code, input logic [7:0] f, input logic [2:0] lo);
    return {code, f, lo};
  endfunction

  // One frame through the host, then a settle time longer than the load latency
  task automatic send(input logic [15:0] w, input logic [4:0] n, input logic [3:0] h, input int loads);
    int k;
    int s0;
    s0 = strobes;
    @(negedge clk);
    word = w;
    nbits = n;
    half = h;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    chk(33'(k < 3000), 33'h1);
    repeat (8) @(negedge clk);
    chk(33'(strobes - s0), 33'(loads));
    chk(cfg, {e_pd, e_com, e_bp, e_up, e_lo});
  endtask

  // Precedence: common reference, then pseudo, then bipolar, then single
  task automatic check_kinds();
    int c;
    logic [1:0] e;
    for (c = 0; c < 16; c++)
    begin
      conv_channel = 4'(c);
      @(negedge clk);
      e = e_com ? 2'h3 : e_pd[7 - c / 2] ? 2'h2 : e_bp[7 - c / 2] ? 2'h1 : 2'h0;
      chk(33'(conv_kind), 33'(e));
      chk(33'(twos_complement), 33'(e == 2'h1));
      chk(33'(channel_kinds[2 * c +: 2]), 33'(e));
    end
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    {e_pd, e_com, e_bp, e_up, e_lo} = '0;
    @(negedge clk);
  endtask

  // Hang guard, far beyond the roughly 1200 cycles the tests need
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    int m;
    start = 1'b0;
    word = 16'h0000;
    nbits = 5'h10;
    half = 4'h3;
    ext_mode = 1'b0;
    int_mode = 1'b0;
    conv_channel = 4'h0;
    bad_count = 0;
    checked = 0;
    {e_pd, e_com, e_bp, e_up, e_lo} = '0;
    do_reset();
    chk(cfg, 33'h0);
    chk(33'(channel_scan_mask), 33'h0);
    $display("test reset values done");
    e_pd = 8'hA5;
    send(wd(acs_pkg::PD_SEL_CODE, 8'hA5, 3'h3), 5'h10, 4'h3, 1);
    e_bp = 8'h3C;
    send(wd(acs_pkg::BIP_SEL_CODE, 8'h3C, 3'h7), 5'h10, 4'h6, 1);
    e_up = 8'h81;
    send(wd(acs_pkg::UPPER_SEL_CODE, 8'h81, 3'h7), 5'h10, 4'h3, 1);
    e_lo = 8'h42;
    send(wd(acs_pkg::LOWER_SEL_CODE, 8'h42, 3'h5), 5'h10, 4'h3, 1);
    $display("test register loads done");
    for (m = 0; m < 4; m++)
    begin
      ext_mode = m[0];
      int_mode = m[1];
      repeat (2) @(negedge clk);
      chk(33'(channel_scan_mask), (m != 0) ? 33'h8142 : 33'h0);
    end
    $display("test scan mask done");
    check_kinds();
    e_com = 1'b1;
    send(wd(acs_pkg::PD_SEL_CODE, 8'hA5, 3'h4), 5'h10, 4'h3, 1);
    check_kinds();
    $display("test coding done");
    send(16'h7FFF, 5'h10, 4'h3, 0);
    send(wd(5'h13, 8'hFF, 3'h7), 5'h10, 4'h3, 0);
    send(wd(acs_pkg::PD_SEL_CODE, 8'hFF, 3'h0), 5'h0A, 4'h3, 0);
    e_pd = 8'h0F;
    e_com = 1'b0;
    send(wd(acs_pkg::PD_SEL_CODE, 8'h0F, 3'h0), 5'h14, 4'h3, 1);
    $display("test refusals done");
    do_reset();
    chk(cfg, 33'h0);
    chk(33'(conv_kind), 33'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule

`default_nettype wire
